// >>> lgp_ports.v
// Port A (GPIO / LCD common) and port B (input / analog / interrupt / LVD) logic
`timescale 1ns/1ns
`include "lgp_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Output pin reads back its latch value
// - Input pin reads the sampled pin level
// - Direction bit 1 output, 0 input
// - Direction and data set pin drive only in GPIO mode
// - Direction register write-only, all bits read 1
// - Nonzero segment field hands pins to LCD commons
// - Reset clears port A data and direction
// - Port B never drives its pins
// - Port B read gives pin levels, no latch
// - Selected analog channel pin reads zero
// - Interrupt select bit routes pin 3, resets 0
// - Other mode bits read one, ignore writes
// - Pin 3 analog on code 0111 unless interrupt
// - Pin 2 analog on code 0110
// - Pin 1 upper threshold input or analog 0101
// - Pin 0 lower threshold input or analog 0100
module lgp_ports (
  // Clock and reset
  input  wire       clk_i,
  input  wire       srst_i,
  // Register port
  input  wire [3:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  // Settings owned by neighbouring units
  input  wire       lvd_upper_ref_select_i,
  input  wire       lvd_lower_ref_select_i,
  // LCD common drive levels for commons 4..1
  input  wire [3:0] lcd_common_i,
  // Port A pins
  input  wire [3:0] port_a_pin_i,
  output reg  [3:0] port_a_pin_o,
  output reg  [3:0] port_a_pin_oe_n_o,
  // Port B pins
  input  wire [3:0] port_b_pin_i,
  // Pin function routing
  output reg        ext_interrupt_one_o,
  output reg        ext_interrupt_one_select_o,
  output reg  [3:0] analog_channel_sel_o,
  output reg        external_upper_threshold_sel_o,
  output reg        external_lower_threshold_sel_o,
  output reg  [3:0] lcd_segment_select_field_o,
  output reg  [3:0] adc_channel_field_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode used by both the write and read paths
  function is_reg;
    input [3:0] a;
    input [3:0] ofs;
    begin
      is_reg = (a == ofs);
    end
  endfunction

  // Returns which port B pin, if any, the channel code connects to the converter
  function [3:0] chan_onehot;
    input [3:0] ch;
    begin
      if (ch == `LGP_CH_AN0) begin
        chan_onehot = 4'h1;
      end else if (ch == `LGP_CH_AN1) begin
        chan_onehot = 4'h2;
      end else if (ch == `LGP_CH_AN2) begin
        chan_onehot = 4'h4;
      end else if (ch == `LGP_CH_AN3) begin
        chan_onehot = 4'h8;
      end else begin
        chan_onehot = 4'h0;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register state
  reg  [3:0] pa_latch_q;
  reg  [3:0] pa_dir_q;
  reg        pb_irq_sel_q;
  reg  [7:0] cfg_q;
  reg  [3:0] pa_in_q;
  reg  [3:0] pb_in_q;

  wire [3:0] seg_field;
  wire [3:0] ch_field;
  wire       gpio_mode;
  wire [3:0] an_hit;
  wire [3:0] an_sel;
  wire [3:0] pa_rd;
  wire [3:0] pb_rd;
  reg  [7:0] rdata_d;

  assign seg_field = cfg_q[`LGP_CFG_SEG_MSB:`LGP_CFG_SEG_LSB];
  assign ch_field  = cfg_q[`LGP_CFG_CH_MSB:`LGP_CFG_CH_LSB];
  assign gpio_mode = (seg_field == `LGP_SEG_GPIO);
  assign an_hit    = chan_onehot(ch_field);

  // Alternate inputs override the analog path on pins 3, 1 and 0
  assign an_sel[3] = an_hit[3] & ~pb_irq_sel_q;
  assign an_sel[2] = an_hit[2];
  assign an_sel[1] = an_hit[1] & ~lvd_upper_ref_select_i;
  assign an_sel[0] = an_hit[0] & ~lvd_lower_ref_select_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin sampling and data read muxing
  always @(posedge clk_i) begin
    if (srst_i) begin
      pa_in_q <= 4'h0;
      pb_in_q <= 4'h0;
    end else begin
      pa_in_q <= port_a_pin_i;
      pb_in_q <= port_b_pin_i;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_bit
      // Latch when output, pin when input
      assign pa_rd[gi] = pa_dir_q[gi] ? pa_latch_q[gi] : pa_in_q[gi];
      // Analog-selected pin reads zero so the converter load does not show as data
      assign pb_rd[gi] = an_sel[gi] ? 1'b0 : pb_in_q[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge clk_i) begin
    if (srst_i) begin
      pa_latch_q   <= `LGP_PA_LATCH_RST;
      pa_dir_q     <= `LGP_PA_DIR_RST;
      pb_irq_sel_q <= `LGP_PB_IRQ_RST;
      cfg_q        <= `LGP_CFG_RST;
    end else if (wr_i) begin
      if (is_reg(addr_i, `LGP_OFS_PA_LATCH)) begin
        pa_latch_q <= wdata_i[3:0];
      end else if (is_reg(addr_i, `LGP_OFS_PA_DIR)) begin
        pa_dir_q <= wdata_i[3:0];
      end else if (is_reg(addr_i, `LGP_OFS_PB_FUNC)) begin
        pb_irq_sel_q <= wdata_i[`LGP_PB_FUNC_IRQ_BIT];
      end else if (is_reg(addr_i, `LGP_OFS_CFG)) begin
        cfg_q <= wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register reads; data stands only in the cycle after the strobe
  always @* begin
    rdata_d = `LGP_UNMAPPED_RD;
    if (is_reg(addr_i, `LGP_OFS_PA_LATCH)) begin
      rdata_d = {`LGP_PA_RSVD_RD, pa_rd};
    end else if (is_reg(addr_i, `LGP_OFS_PA_DIR)) begin
      rdata_d = `LGP_PA_DIR_RD;
    end else if (is_reg(addr_i, `LGP_OFS_PB_LEVELS)) begin
      rdata_d = {4'h0, pb_rd};
    end else if (is_reg(addr_i, `LGP_OFS_PB_FUNC)) begin
      rdata_d = `LGP_PB_FUNC_RSVD | {4'h0, pb_irq_sel_q, 3'h0};
    end else if (is_reg(addr_i, `LGP_OFS_CFG)) begin
      rdata_d = cfg_q;
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rdata_d;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive; outputs are registered so a pin changes one cycle after its cause
  always @(posedge clk_i) begin
    if (srst_i) begin
      port_a_pin_o      <= 4'h0;
      port_a_pin_oe_n_o <= 4'hf;
    end else if (gpio_mode) begin
      port_a_pin_o      <= pa_latch_q;
      port_a_pin_oe_n_o <= ~pa_dir_q;
    end else begin
      port_a_pin_o      <= lcd_common_i;
      port_a_pin_oe_n_o <= 4'h0;
    end
  end

  // Port B has no drivers at all; only routing selects and the gated pin 3 interrupt leave the block
  always @(posedge clk_i) begin
    if (srst_i) begin
      ext_interrupt_one_o            <= 1'b0;
      ext_interrupt_one_select_o     <= 1'b0;
      analog_channel_sel_o           <= 4'h0;
      external_upper_threshold_sel_o <= 1'b0;
      external_lower_threshold_sel_o <= 1'b0;
      lcd_segment_select_field_o     <= 4'h0;
      adc_channel_field_o            <= 4'h0;
    end else begin
      // Interrupt sees pin 3 only while selected; otherwise held low
      ext_interrupt_one_o            <= pb_irq_sel_q & pb_in_q[3];
      ext_interrupt_one_select_o     <= pb_irq_sel_q;
      analog_channel_sel_o           <= an_sel;
      external_upper_threshold_sel_o <= lvd_upper_ref_select_i;
      external_lower_threshold_sel_o <= lvd_lower_ref_select_i;
      lcd_segment_select_field_o     <= seg_field;
      adc_channel_field_o            <= ch_field;
    end
  end

endmodule // lgp_ports

// >>> lgp_regs.vh
// Register offsets, field positions, reset values and codes for the shared LCD/analog GPIO ports
`ifndef LGP_REGS_VH
`define LGP_REGS_VH

// Register offsets, chosen locally
`define LGP_ADDR_W          4
`define LGP_OFS_PA_LATCH    4'h0
`define LGP_OFS_PA_DIR      4'h1
`define LGP_OFS_PB_LEVELS   4'h2
`define LGP_OFS_PB_FUNC     4'h3
`define LGP_OFS_CFG         4'h4

// Field positions
`define LGP_PB_FUNC_IRQ_BIT 3
`define LGP_CFG_SEG_LSB     0
`define LGP_CFG_SEG_MSB     3
`define LGP_CFG_CH_LSB      4
`define LGP_CFG_CH_MSB      7

// Reset values
`define LGP_PA_LATCH_RST    4'h0
`define LGP_PA_DIR_RST      4'h0
`define LGP_PB_IRQ_RST      1'b0
`define LGP_CFG_RST         8'h00

// Fixed read patterns
`define LGP_PA_RSVD_RD      4'hf
`define LGP_PA_DIR_RD       8'hff
`define LGP_PB_FUNC_RSVD    8'hf7
`define LGP_UNMAPPED_RD     8'h00

// Field codes
`define LGP_SEG_GPIO        4'h0
`define LGP_CH_AN0          4'h4
`define LGP_CH_AN1          4'h5
`define LGP_CH_AN2          4'h6
`define LGP_CH_AN3          4'h7

`endif

// >>> lgp_ports_asserts.sv
// Port-level assertions for the shared LCD/analog GPIO ports
`timescale 1ns/1ns
module lgp_ports_asserts (
  // Clock, reset and register port
  input wire       clk_i, srst_i, rd_i,
  input wire [3:0] addr_i,
  input wire [7:0] rdata_o,
  // Pins and pin routing
  input wire [3:0] lcd_common_i, port_a_pin_o, port_a_pin_oe_n_o, port_b_pin_i,
  input wire [3:0] analog_channel_sel_o, lcd_segment_select_field_o,
  input wire       ext_interrupt_one_o, ext_interrupt_one_select_o,
  input wire       external_upper_threshold_sel_o, external_lower_threshold_sel_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  property p_rst; $past(srst_i) |-> port_a_pin_oe_n_o == 4'hf && port_a_pin_o == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  // Both cycles nonzero, so the pin flops have seen the new field
  property p_lcd_oe; lcd_segment_select_field_o != 4'h0 && $past(lcd_segment_select_field_o) != 4'h0
    |-> port_a_pin_oe_n_o == 4'h0; endproperty
  a_lcd_oe: assert property (p_lcd_oe) else $error("lcd pin not driven");
  property p_lcd_val; lcd_segment_select_field_o != 4'h0 && $past(lcd_segment_select_field_o) != 4'h0
    |-> port_a_pin_o == $past(lcd_common_i); endproperty
  a_lcd_val: assert property (p_lcd_val) else $error("lcd common level wrong");
  property p_dir_rd; rd_i && addr_i == 4'h1 |=> rdata_o == 8'hff; endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("direction read wrong");
  property p_func_rd; rd_i && addr_i == 4'h3 |=> (rdata_o | 8'h08) == 8'hff; endproperty
  a_func_rd: assert property (p_func_rd) else $error("mode reserved bits wrong");
  property p_irq; ext_interrupt_one_o == (ext_interrupt_one_select_o & $past(port_b_pin_i[3], 2)); endproperty
  a_irq: assert property (p_irq) else $error("interrupt line wrong");
  property p_up; external_upper_threshold_sel_o && $past(external_upper_threshold_sel_o)
    |-> !analog_channel_sel_o[1]; endproperty
  a_up: assert property (p_up) else $error("pin1 analog while upper ref");
  property p_lo; external_lower_threshold_sel_o && $past(external_lower_threshold_sel_o)
    |-> !analog_channel_sel_o[0]; endproperty
  a_lo: assert property (p_lo) else $error("pin0 analog while lower ref");
endmodule // lgp_ports_asserts
bind lgp_ports lgp_ports_asserts u_chk (.*);

// >>> lgp_pin_model.sv
// Board-side model: resolves port A wires and supplies port B levels
`timescale 1ns/1ns
module lgp_pin_model (
  // Device side
  input  wire [3:0] drive_i,
  input  wire [3:0] drive_oe_n_i,
  // Board side
  input  wire [3:0] board_a_i,
  input  wire [3:0] board_b_i,
  output wire [3:0] pin_a_o,
  output wire [3:0] pin_b_o
);
  // An undriven pin shows the board level, never the last driven value
  assign pin_a_o = (drive_i & ~drive_oe_n_i) | (board_a_i & drive_oe_n_i);
  assign pin_b_o = board_b_i;
endmodule // lgp_pin_model

// >>> lgp_ports_bench.sv
// Self-checking bench for the shared LCD/analog GPIO ports
`timescale 1ns/1ns
module lgp_ports_bench;
  reg        clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, up = 1'b0, lo = 1'b0, irq = 1'b0, rd_seen = 1'b0;
  reg  [3:0] addr_i = 4'h0, lcd_common_i = 4'h0, a_lvl = 4'h0, b_lvl = 4'h0, lat = 4'h0, dir = 4'h0, a;
  reg  [7:0] wdata_i = 8'h00, cfg = 8'h00, d;
  reg  [7:0] expq [$];
  wire [7:0] rdata_o;
  wire [3:0] port_a_pin_i, port_a_pin_o, port_a_pin_oe_n_o, port_b_pin_i;
  wire [7:0] pins = {port_a_pin_oe_n_o, port_a_pin_o & ~port_a_pin_oe_n_o};
  wire [7:0] pins_exp = (cfg[3:0] != 4'h0) ? {4'h0, lcd_common_i} : {~dir, lat & dir};
  integer    mismatches = 0, n_checks = 0, quiet = 0, i;
  initial forever #2 clk_i = ~clk_i;
  lgp_ports u_dut (.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .lvd_upper_ref_select_i(up),
    .lvd_lower_ref_select_i(lo), .lcd_common_i, .port_a_pin_i, .port_a_pin_o, .port_a_pin_oe_n_o, .port_b_pin_i,
    .ext_interrupt_one_o(), .ext_interrupt_one_select_o(), .analog_channel_sel_o(), .adc_channel_field_o(),
    .external_upper_threshold_sel_o(), .external_lower_threshold_sel_o(), .lcd_segment_select_field_o());
  lgp_pin_model u_pins (.drive_i(port_a_pin_o), .drive_oe_n_i(port_a_pin_oe_n_o), .board_a_i(a_lvl),
    .board_b_i(b_lvl), .pin_a_o(port_a_pin_i), .pin_b_o(port_b_pin_i));
  ////////////////////////////////////////////////////////////////////////////
  function [7:0] exp_rd(input [3:0] ad);
    reg [3:0] w, m;
    begin
      w = (cfg[3:0] != 4'h0) ? lcd_common_i : (dir & lat) | (~dir & a_lvl);
      m = (cfg[7:6] == 2'b01) ? 4'h1 << cfg[5:4] : 4'h0;
      m = m & ~{irq, 1'b0, up, lo};
      case (ad)
        4'h0: exp_rd = {4'hf, (dir & lat) | (~dir & w)};
        4'h1: exp_rd = 8'hff;
        4'h2: exp_rd = {4'h0, b_lvl & ~m};
        4'h3: exp_rd = {4'hf, irq, 3'h7};
        4'h4: exp_rd = cfg;
        default: exp_rd = 8'h00;
      endcase
    end
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task op(input w, input r, input [3:0] ad, input [7:0] dt);
    begin
      wr_i <= w;
      rd_i <= r;
      addr_i <= ad;
      wdata_i <= dt;
      if (w) quiet = 0;
      if (w && ad == 4'h0) lat = dt[3:0];
      if (w && ad == 4'h1) dir = dt[3:0];
      if (w && ad == 4'h3) irq = dt[3];
      if (w && ad == 4'h4) cfg = dt;
      if (r) expq.push_back(exp_rd(ad));
      @(posedge clk_i);
    end
  endtask
  task close_out;
    begin
      if (mismatches == 0 && n_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Pins are only judged once every flop after a change has settled
  always @(posedge clk_i) rd_seen <= rd_i;
  always @(negedge clk_i) begin
    if (rd_seen) chk(rdata_o, expq.pop_front());
    if (quiet > 2) chk(pins, pins_exp);
    quiet = quiet + 1;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches = mismatches + 1;
    close_out;
  end
  initial begin
    i = $urandom(25);
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    for (i = 0; i < 400; i = i + 1) begin
      a_lvl <= $urandom;
      b_lvl <= $urandom;
      lcd_common_i <= $urandom;
      {up, lo} <= $urandom;
      a = $urandom % 6;
      d = $urandom;
      // Half the mode writes return to plain I/O so both pin roles get traffic
      if (a == 4'h4 && d[0]) d[3:0] = 4'h0;
      if (a < 4'h2) d[7:4] = 4'hf;
      op(1'b1, 1'b0, a, d);
      repeat (3) op(1'b0, 1'b0, 4'h0, 8'h00);
      for (a = 4'h0; a < 4'h7; a = a + 4'h1) op(1'b0, 1'b1, a, 8'h00);
    end
    op(1'b0, 1'b0, 4'h0, 8'h00);
    repeat (4) @(posedge clk_i);
    close_out;
  end
endmodule // lgp_ports_bench
